// file: rtl/mmd_pkg.sv
// constants for the memory map address decoder
//
// Behaviour
// - fetches use even addresses; data may be byte or word wide
// - decoder covers a 128 KB address space (17 address bits)
// - small flash ends at 0x0FFFF; start depends on installed size
// - vector table is top 16 words of flash, highest at 0x0FFFE
// - RAM begins at 0x0200; end depends on fitted RAM size
// - 0x0100-0x01FF go to 16-bit peripherals, normally word accessed
// - byte access to 16-bit peripherals only even; upper byte reads 0
// - 0x0010-0x00FF go to 8-bit peripherals, normally byte accessed
// - word read of 8-bit peripheral: upper byte undefined
// - word write to 8-bit peripheral stores low byte only
// - special function bytes are lowest 16 bytes, byte access only
// - words at even addresses, low byte even, high byte odd
// - instruction fetch from 0x0000-0x01FF resets the device
package mmd_pkg;
   localparam int ADDR_W = 17;
   localparam logic [16:0] SFB_LAST = 17'h0_000F;
   localparam logic [16:0] P8_FIRST = 17'h0_0010;
   localparam logic [16:0] P8_LAST = 17'h0_00FF;
   localparam logic [16:0] P16_FIRST = 17'h0_0100;
   localparam logic [16:0] P16_LAST = 17'h0_01FF;
   localparam logic [16:0] RAM_FIRST = 17'h0_0200;
   localparam logic [16:0] FLASH_LAST = 17'h0_FFFF;
   localparam logic [16:0] VEC_FIRST = 17'h0_FFE0;
   localparam logic [16:0] VEC_TOP = 17'h0_FFFE;
   localparam logic [16:0] FETCH_RST_LAST = 17'h0_01FF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   typedef enum logic [2:0] {
      MMD_NONE = 3'b000,
      MMD_SFB = 3'b001,
      MMD_P8 = 3'b010,
      MMD_P16 = 3'b011,
      MMD_RAM = 3'b100,
      MMD_FLASH = 3'b101
   } mmd_region_e;
endpackage

// file: rtl/mmd_region_cmp.sv
// region compare: one address against the documented windows
`timescale 1ns/100ps
module mmd_region_cmp #(
   parameter logic [16:0] RAM_LAST = 17'h0_03FF,
   parameter logic [16:0] FLASH_FIRST = 17'h0_C000
) (
   input wire logic [16:0] addr, // byte address under test
   output mmd_pkg::mmd_region_e region, // selected region
   output logic is_vector // address in vector table
);
   // first match wins; gaps decode to none
   always_comb begin
      region = mmd_pkg::MMD_NONE;
      if (addr <= mmd_pkg::SFB_LAST) begin
         region = mmd_pkg::MMD_SFB;
      end else if (addr <= mmd_pkg::P8_LAST) begin
         region = mmd_pkg::MMD_P8;
      end else if (addr <= mmd_pkg::P16_LAST) begin
         region = mmd_pkg::MMD_P16;
      // ram from 0x0200 up to fitted size
      end else if (addr >= mmd_pkg::RAM_FIRST && addr <= RAM_LAST) begin
         region = mmd_pkg::MMD_RAM;
      end else if (addr >= FLASH_FIRST && addr <= mmd_pkg::FLASH_LAST) begin
         region = mmd_pkg::MMD_FLASH;
      end
   end

   assign is_vector = (addr >= mmd_pkg::VEC_FIRST) &&
      (addr <= mmd_pkg::FLASH_LAST);
endmodule // mmd_region_cmp

// file: rtl/mmd_decoder.sv
// memory map decoder and byte/word adapter between cpu and targets
`timescale 1ns/100ps
module mmd_decoder #(
   parameter logic [16:0] RAM_LAST = 17'h0_03FF, // fitted ram end
   parameter logic [16:0] FLASH_FIRST = 17'h0_C000 // installed flash start
) (
   input wire logic clk, // system clock 125 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic req, // cpu access request, one cycle
   input wire logic we, // 1 write, 0 read
   input wire logic byte_en, // 1 byte transfer, 0 word
   input wire logic fetch, // access is instruction fetch
   input wire logic [16:0] addr, // cpu byte address
   input wire logic [15:0] wdata, // cpu write data
   output logic [15:0] rdata, // read data, registered
   output logic rvalid, // read data valid pulse
   output logic [4:0] tgt_sel, // one-hot sfb,p8,p16,ram,flash
   output logic [16:0] tgt_addr, // byte address to target
   output logic tgt_we, // target write strobe
   output logic [1:0] tgt_be, // target byte lanes low,high
   output logic [15:0] tgt_wdata, // lane-placed write data
   input wire logic [15:0] tgt_rdata, // target read data, same cycle
   output logic vec_hit, // access in vector table
   output logic bad_access, // access broke width rules, pulse
   output logic fetch_reset // request device reset, pulse
);
   mmd_pkg::mmd_region_e region;
   logic is_vec;
   logic [16:0] eff_addr;
   logic odd;
   logic [1:0] next_be;
   logic [15:0] next_rdata;
   logic [15:0] lane_wdata;
   logic rule_break;

   assign eff_addr = byte_en ? addr : {addr[16:1], 1'b0};
   assign odd = byte_en & addr[0];

   // full 17-bit compare covers 128 KB
   mmd_region_cmp #(
      .RAM_LAST(RAM_LAST),
      .FLASH_FIRST(FLASH_FIRST)
   ) u_cmp (
      .addr(eff_addr),
      .region(region),
      .is_vector(is_vec)
   );

   // byte lanes: even is low lane, odd is high lane
   always_comb begin
      next_be = 2'b11;
      if (byte_en) begin
         next_be = odd ? 2'b10 : 2'b01;
      end
      // word write to byte peripheral keeps low byte only
      if (!byte_en && we && region == mmd_pkg::MMD_P8) begin
         next_be = 2'b01;
      end
   end

   // byte writes are mirrored on both lanes so targets need no shifter
   assign lane_wdata = byte_en ? {wdata[7:0], wdata[7:0]} : wdata;

   // select lines and strobes go out combinationally with the request
   always_comb begin
      tgt_sel = 5'b0_0000;
      if (req) begin
         case (region)
            mmd_pkg::MMD_SFB: tgt_sel = 5'b0_0001;
            mmd_pkg::MMD_P8: tgt_sel = 5'b0_0010;
            mmd_pkg::MMD_P16: tgt_sel = 5'b0_0100;
            mmd_pkg::MMD_RAM: tgt_sel = 5'b0_1000;
            mmd_pkg::MMD_FLASH: tgt_sel = 5'b1_0000;
            default: tgt_sel = 5'b0_0000;
         endcase
      end
   end
   assign tgt_addr = eff_addr;
   assign tgt_we = req & we & ~fetch;
   assign tgt_be = req ? next_be : 2'b00;
   assign tgt_wdata = lane_wdata;
   assign vec_hit = req & is_vec;

   // read data steering by width and region
   always_comb begin
      next_rdata = tgt_rdata;
      if (byte_en) begin
         // odd byte comes from high lane
         next_rdata = {mmd_pkg::ZERO_BYTE,
            odd ? tgt_rdata[15:8] : tgt_rdata[7:0]};
      end
      // byte read of word peripheral clears upper byte
      if (byte_en && region == mmd_pkg::MMD_P16) begin
         next_rdata = {mmd_pkg::ZERO_BYTE, tgt_rdata[7:0]};
      end
      // word read of byte peripheral: upper byte passed as is
      // which the cpu must treat as undefined
   end

   // width rule checks; the access still runs, only flagged
   always_comb begin
      rule_break = 1'b0;
      if (fetch && addr[0]) begin
         rule_break = 1'b1;
      end
      if (!byte_en && addr[0]) begin
         rule_break = 1'b1;
      end
      // special function bytes are byte only
      if (!byte_en && region == mmd_pkg::MMD_SFB) begin
         rule_break = 1'b1;
      end
      // byte access to word peripherals even only
      if (byte_en && addr[0] && region == mmd_pkg::MMD_P16) begin
         rule_break = 1'b1;
      end
   end

   // read data registered, valid one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req & ~we;
         if (req && !we) begin
            rdata <= next_rdata;
         end
      end
   end

   // error and reset pulses, one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_access <= 1'b0;
         fetch_reset <= 1'b0;
      end else begin
         bad_access <= req & rule_break;
         // fetch from low 512 bytes resets the device
         fetch_reset <= req & fetch & (addr <= mmd_pkg::FETCH_RST_LAST);
      end
   end

   a_fetch_reset: assert property (@(posedge clk) disable iff (!rst_n)
      req && fetch && addr <= 17'h0_01FF |=> fetch_reset)
      else $error("low fetch did not reset");
   a_fetch_ok: assert property (@(posedge clk) disable iff (!rst_n)
      req && fetch && addr > 17'h0_01FF |=> !fetch_reset)
      else $error("spurious fetch reset");
   a_p16_upper: assert property (@(posedge clk) disable iff (!rst_n)
      req && !we && byte_en && addr >= 17'h0_0100 && addr <= 17'h0_01FF
      |=> rvalid && rdata[15:8] == 8'h00)
      else $error("byte read of word peripheral upper not zero");
   a_p8_low_lane: assert property (@(posedge clk) disable iff (!rst_n)
      req && we && !byte_en && tgt_sel == 5'b0_0010 |-> tgt_be == 2'b01)
      else $error("word write to byte peripheral touched high lane");
   a_sfb_word: assert property (@(posedge clk) disable iff (!rst_n)
      req && !byte_en && addr <= 17'h0_000F |=> bad_access)
      else $error("word access to special bytes not flagged");
   a_word_align: assert property (@(posedge clk) disable iff (!rst_n)
      req && !byte_en |-> tgt_addr[0] == 1'b0)
      else $error("word address not aligned");
   a_odd_fetch: assert property (@(posedge clk) disable iff (!rst_n)
      req && fetch && addr[0] |=> bad_access)
      else $error("odd fetch not flagged");
   a_ram_sel: assert property (@(posedge clk) disable iff (!rst_n)
      req && addr == 17'h0_0200 |-> tgt_sel == 5'b0_1000)
      else $error("ram start not selected");
   a_vector: assert property (@(posedge clk) disable iff (!rst_n)
      req && addr == 17'h0_FFFE |-> vec_hit && tgt_sel == 5'b1_0000)
      else $error("top vector not in flash");
   a_p8_sel: assert property (@(posedge clk) disable iff (!rst_n)
      req && addr >= 17'h0_0010 && addr <= 17'h0_00FF
      |-> tgt_sel == 5'b0_0010)
      else $error("byte peripheral not selected");
   a_p16_sel: assert property (@(posedge clk) disable iff (!rst_n)
      req && addr >= 17'h0_0100 && addr <= 17'h0_01FF
      |-> tgt_sel == 5'b0_0100)
      else $error("word peripheral not selected");
   a_above_flash: assert property (@(posedge clk) disable iff (!rst_n)
      req && addr > 17'h0_FFFF |-> tgt_sel == 5'b0_0000)
      else $error("address above flash selected");

   c_word_read: cover property (@(posedge clk) req && !we && !byte_en);
   c_byte_write: cover property (@(posedge clk) req && we && byte_en);
   c_fetch_rst: cover property (@(posedge clk) fetch_reset);
   c_vector: cover property (@(posedge clk) vec_hit);
endmodule // mmd_decoder

// file: tb/mmd_tgt_model.sv
// target side model: byte-lane memory behind every decoded region
`timescale 1ns/100ps
module mmd_tgt_model (
   input wire logic clk, // system clock
   input wire logic [4:0] tgt_sel, // one-hot region select
   input wire logic [16:0] tgt_addr, // target byte address
   input wire logic tgt_we, // write strobe
   input wire logic [1:0] tgt_be, // byte lanes low,high
   input wire logic [15:0] tgt_wdata, // lane-placed write data
   output logic [15:0] tgt_rdata // read data, same cycle
);
   logic [15:0] mem [256];
   logic [15:0] junk = 16'h0000;
   // preset: upper byte 0x5a, lower byte the word index
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = {8'h5A, 8'(i)};
      end
   end
   always @(posedge clk) begin
      junk <= junk + 16'h3c5b;
      if (tgt_we && tgt_sel != 5'h00) begin
         if (tgt_be[0]) mem[tgt_addr[8:1]][7:0] <= tgt_wdata[7:0];
         if (tgt_be[1]) mem[tgt_addr[8:1]][15:8] <= tgt_wdata[15:8];
      end
   end
   // nothing selected: bus floats, so show a moving pattern, not old data
   assign tgt_rdata = (tgt_sel != 5'h00) ? mem[tgt_addr[8:1]] : junk;
endmodule // mmd_tgt_model

// file: tb/mmd_decoder_tb.sv
// self-checking bench for the memory map decoder
`timescale 1ns/100ps
module mmd_decoder_tb;
   logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, we = 1'b0;
   logic byte_en = 1'b0, fetch = 1'b0, rvalid, tgt_we, vec_hit;
   logic bad_access, fetch_reset, s_vec;
   logic [16:0] addr = 17'h0_0000, tgt_addr, s_addr;
   logic [15:0] wdata = 16'h0000, rdata, tgt_wdata, tgt_rdata, s_wd;
   logic [4:0] tgt_sel, s_sel;
   logic [1:0] tgt_be, s_be;
   int err_count = 0, num_checks = 0, cyc = 0;
   mmd_decoder #(.RAM_LAST(17'h0_03FF), .FLASH_FIRST(17'h0_C000)) i_dut (
      .clk(clk), .rst_n(rst_n), .req(req), .we(we), .byte_en(byte_en),
      .fetch(fetch), .addr(addr), .wdata(wdata), .rdata(rdata),
      .rvalid(rvalid), .tgt_sel(tgt_sel), .tgt_addr(tgt_addr),
      .tgt_we(tgt_we), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata),
      .tgt_rdata(tgt_rdata), .vec_hit(vec_hit), .bad_access(bad_access),
      .fetch_reset(fetch_reset));
   mmd_tgt_model i_tgt (.clk(clk), .tgt_sel(tgt_sel), .tgt_addr(tgt_addr),
      .tgt_we(tgt_we), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata),
      .tgt_rdata(tgt_rdata));
   // clock 8 ns
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // hang guard: whole run needs well under 300 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         summarize();
      end
   end
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access: drive at falling edge, grab target side 1 ns later, before the rising edge,
   // release at next falling edge when registered answers are settled
   task automatic acc(input logic w, b, f, input logic [16:0] a,
                      input logic [15:0] d);
      @(negedge clk);
      req = 1'b1; we = w; byte_en = b; fetch = f; addr = a; wdata = d;
      #1;
      s_sel = tgt_sel; s_be = tgt_be; s_addr = tgt_addr;
      s_wd = tgt_wdata; s_vec = vec_hit;
      @(negedge clk);
      req = 1'b0; fetch = 1'b0;
   endtask
   // region edges except 0x0000 and 0x01FF, gaps and vector table by byte reads
   task automatic t_regions();
      logic [16:0] ra [14] = '{17'h0_000F, 17'h0_0010, 17'h0_00FF,
         17'h0_0100, 17'h0_01FE, 17'h0_0200, 17'h0_03FF, 17'h0_0400,
         17'h0_BFFF, 17'h0_C000, 17'h0_FFDF, 17'h0_FFE0, 17'h0_FFFF,
         17'h1_0000};
      logic [5:0] rs [14] = '{6'h01, 6'h02, 6'h02, 6'h04, 6'h04, 6'h08,
         6'h08, 6'h00, 6'h00, 6'h10, 6'h10, 6'h30, 6'h30, 6'h00};
      for (int i = 0; i < 14; i++) begin
         acc(1'b0, 1'b1, 1'b0, ra[i], 16'h0000);
         chk({s_vec, s_sel}, rs[i]);
         chk(rvalid, 1'b1);
         chk(bad_access, 1'b0);
      end
   endtask
   // word and byte lane placement in ram, odd word served one lower
   task automatic t_lanes();
      acc(1'b1, 1'b0, 1'b0, 17'h0_0204, 16'hBEEF);
      chk({s_be, s_wd}, {2'b11, 16'hBEEF});
      acc(1'b0, 1'b0, 1'b0, 17'h0_0205, 16'h0000);
      chk(s_addr, 17'h0_0204);
      chk(rdata, 16'hBEEF);
      chk(bad_access, 1'b1);
      acc(1'b0, 1'b1, 1'b0, 17'h0_0205, 16'h0000);
      chk(rdata, 16'h00BE);
      acc(1'b1, 1'b1, 1'b0, 17'h0_0207, 16'h0012);
      chk(s_be, 2'b10);
   endtask
   // 8-bit, 16-bit and special byte width rules
   task automatic t_widths();
      acc(1'b1, 1'b0, 1'b0, 17'h0_0020, 16'h1234);
      chk(s_be, 2'b01);
      acc(1'b0, 1'b0, 1'b0, 17'h0_0020, 16'h0000);
      chk(rdata[7:0], 8'h34);
      acc(1'b0, 1'b1, 1'b0, 17'h0_0100, 16'h0000);
      chk(rdata, 16'h0080);
      acc(1'b0, 1'b1, 1'b0, 17'h0_0101, 16'h0000);
      chk(bad_access, 1'b1);
      acc(1'b0, 1'b0, 1'b0, 17'h0_0004, 16'h0000);
      chk(bad_access, 1'b1);
   endtask
   // fetches: low area resets, odd fetch is flagged
   task automatic t_fetch();
      acc(1'b0, 1'b0, 1'b1, 17'h0_01FE, 16'h0000);
      chk(fetch_reset, 1'b1);
      acc(1'b0, 1'b0, 1'b1, 17'h0_0200, 16'h0000);
      chk({fetch_reset, bad_access}, 2'b00);
      acc(1'b0, 1'b0, 1'b1, 17'h0_C001, 16'h0000);
      chk(bad_access, 1'b1);
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_regions();
      t_lanes();
      t_widths();
      t_fetch();
      summarize();
   end
endmodule // mmd_decoder_tb
